// ### ipb_burst_sequencer.sv
`timescale 1ns/1ps
module ipb_burst_sequencer #(
  parameter int RAM_NIBBLES = 256,
  parameter int UNIT_CYCLES = ipb_pkg::IPB_UNIT_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire ipb_pkg::ipb_reg_req_s regReq,
  output logic [7:0]                 regRdata,
  input  wire ipb_pkg::ipb_pat_wr_s  patWr,
  input  wire logic                  gestureActive,
  input  wire logic [7:0]            gestureExitValue,
  output logic                       ledDrivePinOut,
  output logic                       ledDrivePinOe,
  output logic                       burstIrq,
  output logic                       mainStatusDone
);
  import ipb_pkg::*;

  if (RAM_NIBBLES != 256)
    $error("RAM_NIBBLES must be 256");

  function automatic logic [10:0] qzLength(input logic [2:0] f);
    qzLength = (11'h002 << f) + 11'h001;
  endfunction : qzLength
  function automatic logic [10:0] symLength(input logic [7:0] n);
    symLength = 11'({n, 2'b00}) + 11'h004;
  endfunction : symLength

  logic [7:0]  ctrlReg;
  logic [7:0]  sharedExitThresholdCfg;
  logic [7:0]  symbolLoopCount;
  logic [7:0]  symbolOffGap;
  logic [7:0]  packetLoopCount;
  logic [7:0]  packetOffGap;
  logic [7:0]  bitTimeSelect;
  logic [7:0]  symbolLengthStart;
  logic        burstBusy;
  logic        burstDoneFlag;
  logic [3:0]  patRam [RAM_NIBBLES];
  ipb_state_e  state;
  ipb_state_e  next_state;
  logic [10:0] phaseLeft;
  logic [10:0] next_phaseLeft;
  logic [9:0]  bitIdx;
  logic [7:0]  symLeft;
  logic [7:0]  pktLeft;
  logic        startBurst;
  logic        bitTick;
  logic        phaseEnd;
  logic        finish;
  logic        curBit;
  logic [2:0]  quietZoneLength;
  logic        quietZoneLevel;

  assign startBurst      = regReq.wr && regReq.addr == IPB_ADDR_SYM_LEN;
  assign quietZoneLength = ctrlReg[IPB_CTRL_QZ_LEN_LSB +: 3];
  assign quietZoneLevel  = ctrlReg[IPB_CTRL_QZ_LEVEL_BIT];

  // ----------------------------------------------------------------
  // Bit-time base
  // ----------------------------------------------------------------
  ipb_bit_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_bit_timer (
    .clk          (clk),
    .rst_n        (rst_n),
    .restart      (startBurst),
    .bitTimeField (bitTimeSelect[5:0]),
    .bitTick      (bitTick)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlReg           <= IPB_REG_RESET;
      symbolLoopCount   <= IPB_REG_RESET;
      symbolOffGap      <= IPB_REG_RESET;
      packetLoopCount   <= IPB_REG_RESET;
      packetOffGap      <= IPB_REG_RESET;
      bitTimeSelect     <= IPB_REG_RESET;
      symbolLengthStart <= IPB_REG_RESET;
    end
    else if (regReq.wr)
      case (regReq.addr)
        IPB_ADDR_CTRL:     ctrlReg           <= regReq.data;
        IPB_ADDR_SYM_LOOP: symbolLoopCount   <= regReq.data;
        IPB_ADDR_SYM_OFF:  symbolOffGap      <= regReq.data;
        IPB_ADDR_PKT_LOOP: packetLoopCount   <= regReq.data;
        IPB_ADDR_PKT_OFF:  packetOffGap      <= regReq.data;
        IPB_ADDR_BIT_TIME: bitTimeSelect     <= regReq.data;
        IPB_ADDR_SYM_LEN:  symbolLengthStart <= regReq.data;
        default:           ;
      endcase
  end

  // Gesture operation has priority over a host write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sharedExitThresholdCfg <= IPB_REG_RESET;
    else if (gestureActive)
      sharedExitThresholdCfg <= gestureExitValue;
    else if (regReq.wr && regReq.addr == IPB_ADDR_EXIT_THR)
      sharedExitThresholdCfg <= regReq.data;
  end

  // ----------------------------------------------------------------
  // Pattern storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (patWr.wr)
      patRam[patWr.addr] <= patWr.data;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else
      case (regReq.addr)
        IPB_ADDR_CTRL:     regRdata <= ctrlReg;
        IPB_ADDR_EXIT_THR: regRdata <= sharedExitThresholdCfg;
        IPB_ADDR_SYM_LOOP: regRdata <= symbolLoopCount;
        IPB_ADDR_SYM_OFF:  regRdata <= symbolOffGap;
        IPB_ADDR_PKT_LOOP: regRdata <= packetLoopCount;
        IPB_ADDR_PKT_OFF:  regRdata <= packetOffGap;
        IPB_ADDR_BIT_TIME: regRdata <= bitTimeSelect;
        IPB_ADDR_SYM_LEN:  regRdata <= symbolLengthStart;
        IPB_ADDR_STATUS:   regRdata <= {6'h00, burstDoneFlag, burstBusy};
        default:           regRdata <= 8'h00;
      endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign phaseEnd = bitTick && phaseLeft == 11'h001;
  assign finish   = state == IPB_QZ_POST && phaseEnd && symLeft == 8'h00 && pktLeft == 8'h00;

  always_comb
  begin
    next_state     = state;
    next_phaseLeft = phaseLeft;
    case (state)
      IPB_IDLE:    next_state = IPB_IDLE;
      IPB_QZ_PRE:
      begin
        if (phaseEnd)
        begin
          next_state     = IPB_SYMBOL;
          next_phaseLeft = symLength(symbolLengthStart);
        end
      end
      IPB_SYMBOL:
      begin
        if (phaseEnd)
        begin
          next_state     = IPB_QZ_POST;
          next_phaseLeft = qzLength(quietZoneLength);
        end
      end
      IPB_QZ_POST:
      begin
        if (phaseEnd && symLeft != 8'h00)
        begin
          next_state     = IPB_SYM_GAP;
          next_phaseLeft = 11'(IPB_SYM_OFF_MULT) * 11'(symbolOffGap) + 11'h001;
        end
        else if (phaseEnd && pktLeft != 8'h00)
        begin
          next_state     = IPB_PKT_GAP;
          next_phaseLeft = 11'(IPB_PKT_OFF_MULT) * (11'(packetOffGap) + 11'h001);
        end
        else if (phaseEnd)
          next_state = IPB_IDLE;
      end
      IPB_SYM_GAP, IPB_PKT_GAP:
      begin
        if (phaseEnd)
        begin
          next_state     = IPB_QZ_PRE;
          next_phaseLeft = qzLength(quietZoneLength);
        end
      end
      default:     next_state = IPB_IDLE;
    endcase
    // A zero-length leading quiet zone is skipped by starting the symbol directly; a trailing one lasts one bit time
    if (next_state == IPB_QZ_PRE && quietZoneLength == 3'h0)
    begin
      next_state     = IPB_SYMBOL;
      next_phaseLeft = symLength(symbolLengthStart);
    end
    else if (next_state == IPB_QZ_POST && quietZoneLength == 3'h0)
      next_phaseLeft = 11'h001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= IPB_IDLE;
      phaseLeft <= 11'h000;
    end
    else if (startBurst)
    begin
      state     <= (quietZoneLength == 3'h0) ? IPB_SYMBOL : IPB_QZ_PRE;
      phaseLeft <= (quietZoneLength == 3'h0) ? symLength(regReq.data) : qzLength(quietZoneLength);
    end
    else
    begin
      state     <= next_state;
      phaseLeft <= (bitTick && state != next_state) ? next_phaseLeft
                 : (bitTick && state != IPB_IDLE)   ? phaseLeft - 11'h001
                 : phaseLeft;
    end
  end

  // Loop counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      symLeft <= 8'h00;
      pktLeft <= 8'h00;
    end
    else if (startBurst)
    begin
      symLeft <= symbolLoopCount;
      pktLeft <= packetLoopCount;
    end
    else if (state == IPB_QZ_POST && phaseEnd && symLeft != 8'h00)
      symLeft <= symLeft - 8'h01;
    else if (state == IPB_QZ_POST && phaseEnd && pktLeft != 8'h00)
    begin
      symLeft <= symbolLoopCount;
      pktLeft <= pktLeft - 8'h01;
    end
  end

  // Bit index within the symbol, from nibble zero upward
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bitIdx <= 10'h000;
    else if (state != IPB_SYMBOL)
      bitIdx <= 10'h000;
    else if (bitTick)
      bitIdx <= bitIdx + 10'h001;
  end

  assign curBit = patRam[bitIdx[9:2]][bitIdx[1:0]];

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      burstBusy <= 1'b0;
    else if (startBurst)
      burstBusy <= 1'b1;
    else if (finish)
      burstBusy <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      burstDoneFlag <= 1'b0;
    else if (finish)
      burstDoneFlag <= 1'b1;
    else if (regReq.wr && regReq.addr == IPB_ADDR_CLEAR)
      burstDoneFlag <= 1'b0;
  end

  assign mainStatusDone = burstDoneFlag;
  assign burstIrq       = burstDoneFlag && ctrlReg[IPB_CTRL_IRQ_EN_BIT];

  // ----------------------------------------------------------------
  // LED pin, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ledDrivePinOut <= 1'b0;
      ledDrivePinOe  <= 1'b0;
    end
    else
      case (state)
        IPB_SYMBOL:
        begin
          ledDrivePinOut <= curBit;
          ledDrivePinOe  <= curBit || (quietZoneLevel && quietZoneLength != 3'h0);
        end
        IPB_QZ_PRE, IPB_QZ_POST:
        begin
          ledDrivePinOut <= 1'b0;
          ledDrivePinOe  <= quietZoneLevel && quietZoneLength != 3'h0;
        end
        default:
        begin
          ledDrivePinOut <= 1'b0;
          ledDrivePinOe  <= 1'b0;
        end
      endcase
  end

endmodule : ipb_burst_sequencer

// ### ipb_pkg.sv
package ipb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IPB_ADDR_CTRL      = 8'ha0;
  localparam logic [7:0] IPB_ADDR_EXIT_THR  = 8'ha1;
  localparam logic [7:0] IPB_ADDR_SYM_LOOP  = 8'ha2;
  localparam logic [7:0] IPB_ADDR_SYM_OFF   = 8'ha3;
  localparam logic [7:0] IPB_ADDR_PKT_LOOP  = 8'ha4;
  localparam logic [7:0] IPB_ADDR_PKT_OFF   = 8'ha5;
  localparam logic [7:0] IPB_ADDR_BIT_TIME  = 8'ha6;
  localparam logic [7:0] IPB_ADDR_SYM_LEN   = 8'ha7;
  localparam logic [7:0] IPB_ADDR_STATUS    = 8'ha8;
  localparam logic [7:0] IPB_ADDR_CLEAR     = 8'ha9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int IPB_CTRL_IRQ_EN_BIT   = 5;
  localparam int IPB_CTRL_QZ_LEVEL_BIT = 3;
  localparam int IPB_CTRL_QZ_LEN_LSB   = 0;
  localparam int IPB_STAT_BUSY_BIT     = 0;
  localparam int IPB_STAT_DONE_BIT     = 1;
  localparam logic [7:0] IPB_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int IPB_CLK_PERIOD_PS = 20000;
  localparam int IPB_BIT_UNIT_PS   = 270000;
  localparam int IPB_BIT_UNIT_NS10 = 2700;
  localparam int IPB_UNIT_CYCLES   = (IPB_BIT_UNIT_NS10 * 100 + (IPB_CLK_PERIOD_PS / 10) * 10 - 1)
                                     / ((IPB_CLK_PERIOD_PS / 10) * 10);
  localparam int IPB_SYM_OFF_MULT  = 2;
  localparam int IPB_PKT_OFF_MULT  = 4;
  localparam int IPB_BITS_PER_NIB  = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ipb_reg_req_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [3:0] data;
  } ipb_pat_wr_s;

  typedef enum logic [5:0] {
    IPB_IDLE    = 6'b000001,
    IPB_QZ_PRE  = 6'b000010,
    IPB_SYMBOL  = 6'b000100,
    IPB_QZ_POST = 6'b001000,
    IPB_SYM_GAP = 6'b010000,
    IPB_PKT_GAP = 6'b100000
  } ipb_state_e;

endpackage : ipb_pkg

// ### ipb_bit_timer.sv
`timescale 1ns/1ps
module ipb_bit_timer #(
  parameter int UNIT_CYCLES = 14
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic [5:0] bitTimeField,
  output logic            bitTick
);
  import ipb_pkg::*;

  initial
  begin
    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 255)
      $error("UNIT_CYCLES out of range");
  end

  logic [7:0] unitCnt;
  logic [5:0] unitsDone;
  logic       unitTick;

  assign unitTick = (unitCnt == 8'(UNIT_CYCLES - 1));

  // ----------------------------------------------------------------
  // 0.27 us base unit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unitCnt <= 8'h00;
    else if (restart || unitTick)
      unitCnt <= 8'h00;
    else
      unitCnt <= unitCnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // Bit-time: field + 1 base units
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unitsDone <= 6'h00;
    else if (restart || (unitTick && unitsDone == bitTimeField))
      unitsDone <= 6'h00;
    else if (unitTick)
      unitsDone <= unitsDone + 6'h01;
  end

  assign bitTick = unitTick && (unitsDone == bitTimeField) && !restart;

endmodule : ipb_bit_timer

// ### ipb_burst_sequencer_chk.sv
`timescale 1ns/1ps
module ipb_burst_sequencer_chk
  import ipb_pkg::*;
#(
  parameter int UNIT_CYCLES = 14
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire ipb_pkg::ipb_reg_req_s regReq,
  input wire logic [7:0]            regRdata,
  input wire logic                  gestureActive,
  input wire logic [7:0]            gestureExitValue,
  input wire logic                  ledDrivePinOut,
  input wire logic                  ledDrivePinOe,
  input wire logic                  burstIrq,
  input wire logic                  mainStatusDone
);
  logic irqEn;
  logic qzLevel;
  logic startW;
  logic clearW;

  assign startW = regReq.wr && regReq.addr == IPB_ADDR_SYM_LEN;
  assign clearW = regReq.wr && regReq.addr == IPB_ADDR_CLEAR;

  // Shadow of the control bits that gate the pin and interrupt
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqEn   <= 1'b0;
      qzLevel <= 1'b0;
    end
    else if (regReq.wr && regReq.addr == IPB_ADDR_CTRL)
    begin
      irqEn   <= regReq.data[IPB_CTRL_IRQ_EN_BIT];
      qzLevel <= regReq.data[IPB_CTRL_QZ_LEVEL_BIT];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_irq_gated_done: assert property (burstIrq == (mainStatusDone && irqEn))
    else $error("interrupt differs from done and enable");
  a_status_done_read: assert property (regReq.addr == IPB_ADDR_STATUS |=>
    regRdata[IPB_STAT_DONE_BIT] == $past(mainStatusDone) && regRdata[7:2] == 6'h00)
    else $error("status read does not show done flag");
  a_start_sets_busy: assert property (startW ##1 regReq.addr == IPB_ADDR_STATUS |=>
    regRdata[IPB_STAT_BUSY_BIT]) else $error("busy not set after start");
  a_done_holds_set: assert property (mainStatusDone && !clearW |=> mainStatusDone)
    else $error("done flag dropped without clear");
  a_idle_led_off: assert property ($rose(mainStatusDone) && !startW |=>
    !ledDrivePinOe ##1 !ledDrivePinOe) else $error("pin driven after burst end");
  a_on_is_driven: assert property (ledDrivePinOut |-> ledDrivePinOe)
    else $error("pin high while released");
  a_low_needs_level: assert property (ledDrivePinOe && !ledDrivePinOut |-> qzLevel)
    else $error("pin driven low without level bit");
  a_gesture_exit_load: assert property ($past(gestureActive) && gestureActive &&
    regReq.addr == IPB_ADDR_EXIT_THR |=> regRdata == $past(gestureExitValue, 2))
    else $error("exit threshold not overwritten");

  c_burst_done: cover property ($rose(mainStatusDone));
  c_irq_raised: cover property (burstIrq);
  c_low_driven: cover property (ledDrivePinOe && !ledDrivePinOut);
endmodule : ipb_burst_sequencer_chk

bind ipb_burst_sequencer ipb_burst_sequencer_chk #(.UNIT_CYCLES(UNIT_CYCLES)) i_ipb_burst_sequencer_chk (
  .clk, .rst_n, .regReq, .regRdata, .gestureActive, .gestureExitValue,
  .ledDrivePinOut, .ledDrivePinOe, .burstIrq, .mainStatusDone);

// ### ipb_led_model.sv
`timescale 1ns/1ps
// Emitter on the pin: tallies lit and sunk cycles and the first lit cycle
module ipb_led_model (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pinOut,
  input  wire logic        pinOe,
  output logic      [15:0] onCnt,
  output logic      [15:0] lowCnt,
  output logic      [15:0] firstOn
);
  logic [15:0] cyc;

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      cyc     <= 16'h0000;
      onCnt   <= 16'h0000;
      lowCnt  <= 16'h0000;
      firstOn <= 16'hffff;
    end
    else
    begin
      cyc <= cyc + 16'h0001;
      if (pinOe === 1'b1 && pinOut === 1'b1)
        onCnt <= onCnt + 16'h0001;
      if (pinOe === 1'b1 && pinOut === 1'b0)
        lowCnt <= lowCnt + 16'h0001;
      if (pinOe === 1'b1 && pinOut === 1'b1 && firstOn == 16'hffff)
        firstOn <= cyc;
    end
  end
endmodule : ipb_led_model

// ### ipb_burst_sequencer_test.sv
`timescale 1ns/1ps
module ipb_burst_sequencer_test;
  import ipb_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         clr;
  logic         gestureActive;
  logic [7:0]   gestureExitValue;
  logic [7:0]   regRdata;
  logic         ledDrivePinOut;
  logic         ledDrivePinOe;
  logic         burstIrq;
  logic         mainStatusDone;
  logic [15:0]  onCnt;
  logic [15:0]  lowCnt;
  logic [15:0]  firstOn;
  logic [7:0]   rd;
  int           n_errors;
  int           comparisons;
  ipb_reg_req_s regReq;
  ipb_pat_wr_s  patWr;

  ipb_burst_sequencer #(.UNIT_CYCLES(2)) i_ipb_burst_sequencer (
    .clk, .rst_n, .regReq, .regRdata, .patWr, .gestureActive, .gestureExitValue,
    .ledDrivePinOut, .ledDrivePinOe, .burstIrq, .mainStatusDone);
  ipb_led_model i_ipb_led_model (
    .clk, .clr, .pinOut(ledDrivePinOut), .pinOe(ledDrivePinOe), .onCnt, .lowCnt, .firstOn);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Address is parked on status after each write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = '{1'b1, a, d};
    clr = (a == IPB_ADDR_SYM_LEN);
    @(negedge clk);
    regReq = '{1'b0, IPB_ADDR_STATUS, 8'h00};
    clr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    regReq.addr = a;
    @(negedge clk);
    rd = regRdata;
  endtask : rd_reg

  task automatic wr_pat(input logic [7:0] a, input logic [3:0] d);
    @(negedge clk);
    patWr = '{1'b1, a, d};
    @(negedge clk);
    patWr.wr = 1'b0;
  endtask : wr_pat

  task automatic t_regs;
    rd_reg(IPB_ADDR_STATUS);
    check({8'h00, rd}, 16'h0000);
    for (int k = 2; k < 7; k++)
    begin
      wr_reg(8'ha0 + 8'(k), 8'h10 + 8'(k));
      rd_reg(8'ha0 + 8'(k));
      check({8'h00, rd}, 16'h0010 + 16'(k));
    end
    wr_reg(IPB_ADDR_STATUS, 8'hff);
    rd_reg(IPB_ADDR_STATUS);
    check({8'h00, rd}, 16'h0000);
    wr_reg(8'hbf, 8'h77);
    rd_reg(8'hbf);
    check({8'h00, rd}, 16'h0000);
    gestureExitValue = 8'h5a;
    gestureActive = 1'b1;
    rd_reg(IPB_ADDR_EXIT_THR);
    check({8'h00, rd}, 16'h005a);
    gestureActive = 1'b0;
    wr_reg(IPB_ADDR_EXIT_THR, 8'h00);
    rd_reg(IPB_ADDR_EXIT_THR);
    check({8'h00, rd}, 16'h0000);
  endtask : t_regs

  task automatic cfg(input logic [7:0] c, bt, sl, so, pl, po);
    wr_reg(IPB_ADDR_CTRL, c);
    wr_reg(IPB_ADDR_BIT_TIME, bt);
    wr_reg(IPB_ADDR_SYM_LOOP, sl);
    wr_reg(IPB_ADDR_SYM_OFF, so);
    wr_reg(IPB_ADDR_PKT_LOOP, pl);
    wr_reg(IPB_ADDR_PKT_OFF, po);
  endtask : cfg

  // A total of zero or a low count of ffff skips that figure
  task automatic run(input logic [7:0] len, input logic [15:0] total, on, low, first, input logic irq);
    int n;
    wr_reg(IPB_ADDR_SYM_LEN, len);
    n = 1;
    while (mainStatusDone !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000)
    begin
      n_errors++;
      end_of_test;
    end
    if (total != 16'h0000)
      check(16'(n), total);
    check(16'(mainStatusDone), 16'h0001);
    rd_reg(IPB_ADDR_STATUS);
    check({8'h00, rd}, 16'h0002);
    check(16'(burstIrq), 16'(irq));
    check(onCnt, on);
    if (low != 16'hffff)
      check(lowCnt, low);
    check(firstOn, first);
    wr_reg(IPB_ADDR_CLEAR, 8'h00);
    rd_reg(IPB_ADDR_STATUS);
    check({8'h00, rd}, 16'h0000);
    check(16'(mainStatusDone), 16'h0000);
    check(16'(burstIrq), 16'h0000);
  endtask : run

  task automatic t_restart;
    wr_reg(IPB_ADDR_SYM_LEN, 8'h01);
    rd_reg(IPB_ADDR_STATUS);
    check({8'h00, rd}, 16'h0001);
    run(8'h01, 16'h00a5, 16'h0018, 16'hffff, 16'h000d, 1'b1);
  endtask : t_restart

  initial
  begin
    rst_n = 1'b0;
    clr = 1'b0;
    gestureActive = 1'b0;
    gestureExitValue = 8'h00;
    regReq = '0;
    patWr = '0;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    wr_pat(8'h00, 4'ha);
    wr_pat(8'h01, 4'h1);
    cfg(8'h29, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00);
    run(8'h01, 16'h00a5, 16'h0018, 16'h0078, 16'h000d, 1'b1);
    t_restart;
    cfg(8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
    run(8'h00, 16'h0000, 16'h0008, 16'h0000, 16'h0005, 1'b0);
    end_of_test;
  end
endmodule : ipb_burst_sequencer_test
